// ### hdl/pcr_defs.svh
// Register offsets, field positions, reset values and timing counts of the pulse counter registers
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

`define PCR_OFS_WRAP_LIMIT      8'h10
`define PCR_OFS_WRAP_BUF        8'h14
`define PCR_OFS_FLAGS           8'h18
`define PCR_OFS_FLAG_SET        8'h1c
`define PCR_OFS_FLAG_CLR        8'h20
`define PCR_OFS_FLAG_EN         8'h24
`define PCR_OFS_ROUTE           8'h28
`define PCR_OFS_HOLD            8'h2c
`define PCR_OFS_SYNC            8'h30
`define PCR_OFS_AUX             8'h38
`define PCR_OFS_INPUT           8'h3c
`define PCR_OFS_CTRL            8'h00
`define PCR_OFS_CMD             8'h04

`define PCR_WRAP_RESET          16'h00ff
`define PCR_AUX_RESET           16'h0000

`define PCR_FLAG_UF             0
`define PCR_FLAG_OF             1
`define PCR_FLAG_DIR            2
`define PCR_FLAG_AUX_OVERFLOW_FLAG          3

`define PCR_ROUTE_LO            8
`define PCR_ROUTE_HI            10
`define PCR_IN0_SEL_LO          0
`define PCR_IN0_SEL_HI          3
`define PCR_IN0_EN              4
`define PCR_IN1_SEL_LO          6
`define PCR_IN1_SEL_HI          9
`define PCR_IN1_EN              10

`define PCR_SYNC_CTRL           0
`define PCR_SYNC_CMD            1
`define PCR_SYNC_WRAP           2

`define PCR_CTRL_QUAD_LO        0
`define PCR_CTRL_QUAD_HI        1
`define PCR_CTRL_QUAD_CODE      2'h3
`define PCR_CTRL_WIDTH          16
`define PCR_CMD_WIDTH           2
`define PCR_TRANSFER_CYCLES     4'h3
`endif

// ### hdl/pcr_pkg.sv
// Types shared by the pulse counter register bank
package pcr_pkg;
    typedef enum logic [1:0] {
        XFER_IDLE,
        XFER_BUSY
    } pcr_xfer_t;

    typedef struct packed {
        logic        up;
        logic        down;
        logic        dir_change;
        logic        aux_up;
    } pcr_events_t;

    typedef struct packed {
        logic [15:0] wrap_limit;
        logic [15:0] wrap_buf;
        logic [3:0]  flags;
        logic [3:0]  flag_en;
        logic [2:0]  route;
        logic        hold;
        logic [2:0]  pending;
        logic [15:0] ctrl_sh;
        logic [15:0] ctrl_lf;
        logic [1:0]  cmd_sh;
        logic [1:0]  cmd_pulse;
        logic [15:0] aux;
        logic [10:0] input_sel;
        logic [15:0] count;
        logic        in0;
        logic        in1;
        pcr_xfer_t   xfer;
        logic [3:0]  xfer_cnt;
        logic [31:0] rdata;
        logic        irq;
    } pcr_state_t;
endpackage

// ### hdl/pcr_regs.sv
// Pulse counter register bank: wrap limit, flags, interrupt, update hold and input select
`timescale 1ns/1ps
`include "pcr_defs.svh"

// What this block does
// - Down past zero reloads count from wrap limit
// - Up past wrap limit loads zero
// - Buffer write copies into wrap limit
// - Aux overflow sets flag bit 3
// - Direction change sets bit 2, quadrature only
// - Overflow sets bit 1, underflow bit 0
// - Writing one to set view sets flag
// - Writing one to clear view clears flag
// - Four read-write enable bits, reset zero
// - Hold defers transfers, released all together
// - Without hold, a write lands five cycles later when no transfer is busy
// - Pending bits show synchronisation in progress
// - Aux count readable, hardware updated
// - Bit 10 routes event channel to second input
// - Bits 9:6 choose second input channel
// - Bits 3:0 and 4 steer first input
module pcr_regs #(
    parameter int CHANNELS = 12
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // Register port
    input  wire logic [7:0]           addr,
    input  wire logic [31:0]          wdata,
    input  wire logic                 wr_stb,
    input  wire logic                 rd_stb,
    output logic      [31:0]          rdata,
    // Counting engine
    input  wire pcr_pkg::pcr_events_t events,
    input  wire logic                 pin_in0,
    input  wire logic                 pin_in1,
    input  wire logic [CHANNELS-1:0]  event_ch,
    output logic                      first_count_input,
    output logic                      second_count_input,
    output logic      [15:0]          count_value,
    output logic      [15:0]          ctrl_value,
    output logic      [1:0]           cmd_pulse,
    output logic      [2:0]           route_location,
    // Interrupt
    output logic                      irq
);
    pcr_pkg::pcr_state_t s_ff;
    pcr_pkg::pcr_state_t nxt_s;

    logic [3:0] fl;
    logic [3:0] ev_flags;
    logic       quad;
    logic       sel_in0;
    logic       sel_in1;

    // ****************************************
    // Input routing
    // ****************************************
    always_comb begin
        sel_in0 = pin_in0;
        sel_in1 = pin_in1;
        // Channel codes past the last channel read as low rather than wrapping
        if (s_ff.input_sel[`PCR_IN0_EN]) begin
            sel_in0 = (32'(s_ff.input_sel[`PCR_IN0_SEL_HI:`PCR_IN0_SEL_LO]) < CHANNELS) &&
                      event_ch[s_ff.input_sel[`PCR_IN0_SEL_HI:`PCR_IN0_SEL_LO]];
        end
        if (s_ff.input_sel[`PCR_IN1_EN]) begin
            sel_in1 = (32'(s_ff.input_sel[`PCR_IN1_SEL_HI:`PCR_IN1_SEL_LO]) < CHANNELS) &&
                      event_ch[s_ff.input_sel[`PCR_IN1_SEL_HI:`PCR_IN1_SEL_LO]];
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_s = s_ff;
        nxt_s.cmd_pulse = 2'h0;
        nxt_s.in0 = sel_in0;
        nxt_s.in1 = sel_in1;
        nxt_s.rdata = 32'h0;
        quad = (s_ff.ctrl_lf[`PCR_CTRL_QUAD_HI:`PCR_CTRL_QUAD_LO] == `PCR_CTRL_QUAD_CODE);

        // Count value with wrap behaviour
        ev_flags = 4'h0;
        if (events.up && !events.down) begin
            if (s_ff.count >= s_ff.wrap_limit) begin
                nxt_s.count = 16'h0000;
                ev_flags[`PCR_FLAG_OF] = 1'b1;
            end else begin
                nxt_s.count = s_ff.count + 16'h0001;
            end
        end else if (events.down && !events.up) begin
            if (s_ff.count == 16'h0000) begin
                nxt_s.count = s_ff.wrap_limit;
                ev_flags[`PCR_FLAG_UF] = 1'b1;
            end else begin
                nxt_s.count = s_ff.count - 16'h0001;
            end
        end
        if (s_ff.cmd_pulse[0]) begin
            nxt_s.count = s_ff.wrap_limit;
        end
        if (events.aux_up) begin
            nxt_s.aux = s_ff.aux + 16'h0001;
            ev_flags[`PCR_FLAG_AUX_OVERFLOW_FLAG] = (s_ff.aux == 16'hffff);
        end
        ev_flags[`PCR_FLAG_DIR] = events.dir_change && quad;

        // Flags: hardware and set view win over the clear view
        fl = s_ff.flags;
        if (wr_stb && addr == `PCR_OFS_FLAG_CLR) begin
            fl = fl & ~wdata[3:0];
        end
        if (wr_stb && addr == `PCR_OFS_FLAG_SET) begin
            fl = fl | wdata[3:0];
        end
        nxt_s.flags = fl | ev_flags;

        // Writes; reserved bits are dropped, software keeps them zero
        if (wr_stb) begin
            case (addr)
                `PCR_OFS_WRAP_BUF: begin
                    nxt_s.wrap_buf = wdata[15:0];
                    nxt_s.pending[`PCR_SYNC_WRAP] = 1'b1;
                end
                `PCR_OFS_CTRL: begin
                    nxt_s.ctrl_sh = wdata[15:0];
                    nxt_s.pending[`PCR_SYNC_CTRL] = 1'b1;
                end
                `PCR_OFS_CMD: begin
                    nxt_s.cmd_sh = wdata[1:0];
                    nxt_s.pending[`PCR_SYNC_CMD] = 1'b1;
                end
                `PCR_OFS_FLAG_EN: nxt_s.flag_en = wdata[3:0];
                `PCR_OFS_ROUTE:   nxt_s.route = wdata[`PCR_ROUTE_HI:`PCR_ROUTE_LO];
                `PCR_OFS_HOLD:    nxt_s.hold = wdata[0];
                `PCR_OFS_AUX:     nxt_s.aux = wdata[15:0];
                `PCR_OFS_INPUT:   nxt_s.input_sel = wdata[10:0];
                default: begin
                end
            endcase
        end

        // Transfer into the counter domain: models the slow-side latency
        case (s_ff.xfer)
            pcr_pkg::XFER_IDLE: begin
                if (s_ff.pending != 3'h0 && !s_ff.hold) begin
                    nxt_s.xfer = pcr_pkg::XFER_BUSY;
                    nxt_s.xfer_cnt = `PCR_TRANSFER_CYCLES;
                end
            end
            pcr_pkg::XFER_BUSY: begin
                if (s_ff.xfer_cnt != 4'h0) begin
                    nxt_s.xfer_cnt = s_ff.xfer_cnt - 4'h1;
                end else begin
                    // All pending values land together
                    if (s_ff.pending[`PCR_SYNC_WRAP]) begin
                        nxt_s.wrap_limit = s_ff.wrap_buf;
                    end
                    if (s_ff.pending[`PCR_SYNC_CTRL]) begin
                        nxt_s.ctrl_lf = s_ff.ctrl_sh;
                    end
                    if (s_ff.pending[`PCR_SYNC_CMD]) begin
                        nxt_s.cmd_pulse = s_ff.cmd_sh;
                    end
                    nxt_s.pending = 3'h0;
                    nxt_s.xfer = pcr_pkg::XFER_IDLE;
                end
            end
            default: nxt_s.xfer = pcr_pkg::XFER_IDLE;
        endcase
        // A write landing during the final transfer cycle stays pending for another round
        if (wr_stb && s_ff.xfer == pcr_pkg::XFER_BUSY && s_ff.xfer_cnt == 4'h0) begin
            case (addr)
                `PCR_OFS_WRAP_BUF: nxt_s.pending[`PCR_SYNC_WRAP] = 1'b1;
                `PCR_OFS_CTRL:     nxt_s.pending[`PCR_SYNC_CTRL] = 1'b1;
                `PCR_OFS_CMD:      nxt_s.pending[`PCR_SYNC_CMD] = 1'b1;
                default: begin
                end
            endcase
        end

        // Reads, answer one cycle later; unmapped offsets read zero
        if (rd_stb) begin
            case (addr)
                `PCR_OFS_CTRL:       nxt_s.rdata = {16'h0, s_ff.ctrl_sh};
                `PCR_OFS_WRAP_LIMIT: nxt_s.rdata = {16'h0, s_ff.wrap_limit};
                `PCR_OFS_WRAP_BUF:   nxt_s.rdata = {16'h0, s_ff.wrap_buf};
                `PCR_OFS_FLAGS:      nxt_s.rdata = {28'h0, s_ff.flags};
                `PCR_OFS_FLAG_EN:    nxt_s.rdata = {28'h0, s_ff.flag_en};
                `PCR_OFS_ROUTE:      nxt_s.rdata = {21'h0, s_ff.route, 8'h00};
                `PCR_OFS_HOLD:       nxt_s.rdata = {31'h0, s_ff.hold};
                `PCR_OFS_SYNC:       nxt_s.rdata = {29'h0, s_ff.pending};
                `PCR_OFS_AUX:        nxt_s.rdata = {16'h0, s_ff.aux};
                `PCR_OFS_INPUT:      nxt_s.rdata = {21'h0, s_ff.input_sel};
                default:             nxt_s.rdata = 32'h0;
            endcase
        end

        nxt_s.irq = |(nxt_s.flags & nxt_s.flag_en);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '{wrap_limit: `PCR_WRAP_RESET, wrap_buf: `PCR_WRAP_RESET,
                      aux: `PCR_AUX_RESET, xfer: pcr_pkg::XFER_IDLE, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rdata              = s_ff.rdata;
    assign irq                = s_ff.irq;
    assign first_count_input  = s_ff.in0;
    assign second_count_input = s_ff.in1;
    assign count_value        = s_ff.count;
    assign ctrl_value         = s_ff.ctrl_lf;
    assign cmd_pulse          = s_ff.cmd_pulse;
    assign route_location     = s_ff.route;
endmodule

// ### test/pcr_regs_properties.sv
// Port-level assertions for the pulse counter register bank
`timescale 1ns/1ps
`include "pcr_defs.svh"
module pcr_regs_properties #(
    parameter int CHANNELS = 12
) (
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 nrst,
    // Register port
    input wire logic [7:0]           addr,
    input wire logic [31:0]          wdata,
    input wire logic                 wr_stb,
    input wire logic                 rd_stb,
    input wire logic [31:0]          rdata,
    // Engine side
    input wire pcr_pkg::pcr_events_t events,
    input wire logic [1:0]           cmd_pulse,
    input wire logic                 irq
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic cause;
    // Only a write or an engine event may move the interrupt up
    assign cause = wr_stb || (events != 4'h0);
    sequence set_all;
        wr_stb && addr == `PCR_OFS_FLAG_SET && wdata[3:0] == 4'hf;
    endsequence
    sequence clr_all;
        wr_stb && addr == `PCR_OFS_FLAG_CLR && wdata[3:0] == 4'hf && events == 4'h0;
    endsequence
    sequence rd_flags;
        rd_stb && addr == `PCR_OFS_FLAGS && events == 4'h0;
    endsequence
    flag_set_read_a: assert property (set_all ##2 rd_flags |=> rdata[3:0] == 4'hf)
        else $error("flags not set by set view");
    flag_clr_read_a: assert property (clr_all ##1 (events == 4'h0 && !wr_stb) ##1 rd_flags
        |=> rdata[3:0] == 4'h0)
        else $error("flags not cleared by clear view");
    irq_rise_cause_a: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2))
        else $error("interrupt rose without cause");
    irq_fall_cause_a: assert property ($fell(irq) |-> $past(wr_stb) || $past(wr_stb, 2))
        else $error("interrupt fell without write");
    rd_idle_zero_a: assert property (!rd_stb |=> rdata == 32'h0)
        else $error("read data outside read slot");
    unmapped_rd_a: assert property (rd_stb && addr == 8'h34 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    upper_bits_a: assert property (rd_stb |=> rdata[31:16] == 16'h0)
        else $error("reserved read bits set");
    cmd_single_a: assert property (cmd_pulse != 2'h0 |=> cmd_pulse == 2'h0)
        else $error("command pulse too long");
endmodule
bind pcr_regs pcr_regs_properties #(.CHANNELS(CHANNELS)) u_chk (.clk_sys(clk_sys), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .events(events), .cmd_pulse(cmd_pulse), .irq(irq));

// ### test/pcr_sensor.sv
// Quadrature sensor model driving the two count pins
`timescale 1ns/1ps
module pcr_sensor (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Step request and pins
    input  wire logic run,
    output logic      pin_a,
    output logic      pin_b
);
    logic [1:0] phase_ff;
    // Gray steps: one pin moves per step, as on a real encoder
    always_ff @(posedge clk_sys or negedge nrst)
        if (!nrst) phase_ff <= 2'h0;
        else if (run) phase_ff <= phase_ff + 2'h1;
    assign pin_a = phase_ff[1];
    assign pin_b = phase_ff[1] ^ phase_ff[0];
endmodule

// ### test/pcr_regs_tb.sv
// Self-checking bench for the pulse counter register bank
`timescale 1ns/1ps
module pcr_regs_tb;
    logic                 clk_sys, nrst, wr_stb, rd_stb, run, pa, pb, fi, si, irq;
    logic [7:0]           addr;
    logic [31:0]          wdata, rdata;
    logic [11:0]          ch;
    logic [15:0]          cnt, ctl;
    logic [3:0]           e;
    pcr_pkg::pcr_events_t ev;
    int                   failures, cmp_count, flags, en, s, k, wrap, c, aux;
    logic [7:0]           ra [9] = '{8'h10, 8'h14, 8'h18, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h38, 8'h3c};
    pcr_regs #(.CHANNELS(12)) dut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .events(ev), .pin_in0(pa), .pin_in1(pb),
        .event_ch(ch), .first_count_input(fi), .second_count_input(si), .count_value(cnt),
        .ctrl_value(ctl), .cmd_pulse(), .route_location(), .irq(irq));
    pcr_sensor sensor (.clk_sys(clk_sys), .nrst(nrst), .run(run), .pin_a(pa), .pin_b(pb));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Read compares against d; a gap cycle follows so strobes never re-assign in one step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= w;
        rd_stb <= !w;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        #1 if (!w) chk(rdata, d);
        @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (4000) @(posedge clk_sys);
        failures++;
        end_of_test();
    end
    initial begin
        {nrst, wr_stb, rd_stb, run, addr, wdata, ch, ev} = '0;
        {failures, cmp_count, flags, en, c, aux} = '0;
        void'($urandom(32'h5eda));
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        foreach (ra[i]) bus(0, ra[i], i < 2 ? 32'hff : 32'h0);
        bus(1, 8'h18, 32'hf);
        bus(0, 8'h18, 32'h0);
        bus(0, 8'h34, 32'h0);
        bus(1, 8'h1c, 32'hf);
        bus(0, 8'h18, 32'hf);
        bus(1, 8'h20, 32'hf);
        bus(0, 8'h18, 32'h0);
        repeat (6) begin
            s = $urandom & 15;
            en = $urandom & 15;
            k = $urandom & 15;
            bus(1, 8'h1c, s);
            bus(1, 8'h24, en);
            bus(1, 8'h20, k);
            flags = (flags | s) & ~k;
            bus(0, 8'h18, flags);
            bus(0, 8'h24, en);
            chk(irq, (flags & en) != 0);
        end
        for (int q = 0; q < 2; q++) begin
            bus(1, 8'h00, q * 3);
            wrap = 2 + ($urandom & 3);
            bus(1, 8'h14, wrap);
            repeat (8) @(posedge clk_sys);
            chk(ctl, q * 3);
            bus(0, 8'h10, wrap);
            bus(1, 8'h38, 32'hfffe);
            aux = 16'hfffe;
            repeat (24) begin
                e = 4'h1 << ($urandom & 3);
                ev <= e;
                @(posedge clk_sys);
                ev <= 4'h0;
                @(posedge clk_sys);
                if (e == 4'h8) flags |= (c >= wrap) ? 2 : 0;
                if (e == 4'h8) c = (c >= wrap) ? 0 : c + 1;
                if (e == 4'h4) flags |= (c == 0) ? 1 : 0;
                if (e == 4'h4) c = (c == 0) ? wrap : c - 1;
                if (e == 4'h1) flags |= (aux == 16'hffff) ? 8 : 0;
                if (e == 4'h1) aux = (aux + 1) & 16'hffff;
                if (e == 4'h2) flags |= q * 4;
                #1 chk(cnt, c);
            end
            bus(0, 8'h38, aux);
            bus(0, 8'h18, flags);
            bus(1, 8'h20, 32'hf);
            flags = 0;
        end
        bus(1, 8'h2c, 32'h1);
        bus(1, 8'h14, 32'h7);
        repeat (8) @(posedge clk_sys);
        bus(0, 8'h30, 32'h4);
        bus(0, 8'h10, wrap);
        bus(1, 8'h2c, 32'h0);
        repeat (8) @(posedge clk_sys);
        bus(0, 8'h30, 32'h0);
        bus(0, 8'h10, 32'h7);
        bus(0, 8'h14, 32'h7);
        bus(1, 8'h04, 32'h1);
        bus(0, 8'h30, 32'h2);
        repeat (8) @(posedge clk_sys);
        #1 chk(cnt, 16'h7);
        for (int j = 0; j < 12; j++) begin
            ch <= $urandom;
            bus(1, 8'h3c, {21'h0, 1'b1, j[3:0], 2'h1, j[3:0]});
            #1 chk({fi, si}, {ch[j], ch[j]});
        end
        bus(1, 8'h3c, 32'h0);
        repeat (4) begin
            run <= 1'b1;
            @(posedge clk_sys);
            run <= 1'b0;
            repeat (2) @(posedge clk_sys);
            #1 chk({fi, si}, {pa, pb});
        end
        end_of_test();
    end
endmodule
